// File: design/dpa_channel.sv
// One alarm channel: condition, delay, silence, latch and relay
`timescale 1ns/1ps
module dpa_channel (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic tick_i,
  input wire dpa_pkg::dpa_cfg_s cfg_i,
  input wire logic [11:0] delay_i,
  input wire logic [11:0] silence_i,
  input wire logic signed [39:0] disp_i,
  input wire logic signed [39:0] sp_i,
  input wire logic signed [39:0] hyst_i,
  input wire logic accept_i,
  input wire logic clear_i,
  input wire logic loop_break_i,
  output logic cond_o,
  output logic active_o,
  output logic pending_o,
  output logic relay_o
);
  dpa_pkg::dpa_ch_e state;
  logic [11:0] timer;
  logic next_cond;

  always_comb
  begin
    next_cond = cond_o;
    if (!cfg_i.enable)
      next_cond = 1'b0;
    else if (cfg_i.high)
    begin
      if (disp_i >= sp_i)
        next_cond = 1'b1;
      else if (disp_i < sp_i - hyst_i)
        next_cond = 1'b0;
    end
    else
    begin
      if (disp_i <= sp_i)
        next_cond = 1'b1;
      else if (disp_i > sp_i + hyst_i)
        next_cond = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cond_o <= 1'b0;
    else
      cond_o <= next_cond;
  end

  // A tick is only counted once it has fully elapsed, so the wait
  // lies between the setting and one second more, never less.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= dpa_pkg::CH_IDLE;
      timer <= '0;
    end
    else if (!cfg_i.enable)
    begin
      state <= dpa_pkg::CH_IDLE;
      timer <= '0;
    end
    else
    begin
      unique case (state)
        dpa_pkg::CH_IDLE:
          if (cond_o)
          begin
            timer <= '0;
            state <= (delay_i == 12'h000) ? dpa_pkg::CH_ACTIVE
                                          : dpa_pkg::CH_DELAY;
          end
        dpa_pkg::CH_DELAY:
          if (!cond_o)
            state <= dpa_pkg::CH_IDLE;
          else if (tick_i)
          begin
            if (timer >= delay_i)
              state <= dpa_pkg::CH_ACTIVE;
            else
              timer <= timer + 12'h001;
          end
        dpa_pkg::CH_ACTIVE:
          if (accept_i && silence_i != 12'h000)
          begin
            state <= dpa_pkg::CH_SILENCE;
            timer <= '0;
          end
          else if (!cond_o && (!cfg_i.latch || clear_i))
            state <= dpa_pkg::CH_IDLE;
        dpa_pkg::CH_SILENCE:
          if (!cond_o)
            state <= dpa_pkg::CH_IDLE;
          else if (tick_i)
          begin
            if (timer >= silence_i)
              state <= dpa_pkg::CH_ACTIVE;
            else
              timer <= timer + 12'h001;
          end
      endcase
    end
  end

  assign active_o = (state == dpa_pkg::CH_ACTIVE);
  assign pending_o = (state == dpa_pkg::CH_DELAY) ||
                     (state == dpa_pkg::CH_SILENCE);

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      relay_o <= 1'b0;
    else if (loop_break_i)
      relay_o <= 1'b0;
    else
      relay_o <= cfg_i.rest_energised ^ (state == dpa_pkg::CH_ACTIVE);
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_loop_break_relay: assert property (
    loop_break_i |=> !relay_o) else $error("relay on during loop break");
  a_zero_delay_fire: assert property (
    cfg_i.enable && state == dpa_pkg::CH_IDLE && cond_o && delay_i == 0
    |=> active_o) else $error("zero delay did not activate");
  a_delay_restart: assert property (
    cfg_i.enable && state == dpa_pkg::CH_DELAY && !cond_o
    |=> state == dpa_pkg::CH_IDLE) else $error("delay not restarted");
  a_accept_silence: assert property (
    cfg_i.enable && active_o && accept_i && silence_i != 12'h000
    |=> !active_o ##1 (relay_o == $past(cfg_i.rest_energised)
        || $past(loop_break_i)))
    else $error("accept did not silence output");
  a_latch_holds: assert property (
    cfg_i.enable && active_o && cfg_i.latch && !clear_i && !accept_i
    |=> active_o) else $error("latched output dropped");
  a_disable_clears: assert property (
    !cfg_i.enable |=> state == dpa_pkg::CH_IDLE && timer == 0)
    else $error("disable did not clear timers");
  a_high_set: assert property (
    cfg_i.enable && cfg_i.high && disp_i >= sp_i |=> cond_o)
    else $error("high condition not set at setpoint");
  a_low_set: assert property (
    cfg_i.enable && !cfg_i.high && disp_i <= sp_i |=> cond_o)
    else $error("low condition not set at setpoint");

  c_delay_to_active: cover property (
    state == dpa_pkg::CH_DELAY ##1 active_o);
  c_silence_reactivate: cover property (
    state == dpa_pkg::CH_SILENCE ##1 active_o);
endmodule

// File: design/dpa_dual_alarm.sv
// Dual process alarm top: registers, buttons, setpoint access, display
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
module dpa_dual_alarm #(
  parameter int unsigned TICK_CYCLES = dpa_pkg::TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  input wire logic btn_p_i,
  input wire logic btn_up_i,
  input wire logic btn_down_i,
  input wire logic btn_enter_i,
  input wire dpa_pkg::dpa_num_s display_i,
  input wire logic loop_break_i,
  output logic [1:0] relay_o,
  output logic [1:0] annunciator_o,
  output logic [2:0] disp_colour_o,
  output logic disp_alarm_colour_o,
  output logic show_label_o,
  output logic label_sel_o,
  output dpa_pkg::dpa_edit_s edit_o
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {ED_DISPLAY, ED_CODE, ED_SELECT, ED_EDIT}
    dpa_ed_e;

  dpa_pkg::dpa_cfg_s cfg [2];
  dpa_pkg::dpa_num_s sp [2];
  dpa_pkg::dpa_num_s hyst [2];
  logic [11:0] delay_s [2];
  logic [11:0] silence_s [2];
  logic access_en;
  logic [15:0] access_code;
  logic [1:0] cond, active, pending;
  logic [TW-1:0] tick_cnt;
  logic tick, blink;
  logic [1:0] label_seq;
  logic [3:0] btn_sync, btn_prev;
  logic p_rise, up_rise, down_rise, enter_rise, combo_rise;
  logic accept, clear_latch;
  dpa_ed_e ed_state;
  logic ed_sel;
  logic [2:0] ed_pos;
  dpa_pkg::dpa_num_s ed_buf;
  logic [15:0] code_buf;
  logic store_sp;
  logic signed [39:0] disp_scaled;

  // Bus word index split into channel and per-channel offset
  function automatic logic [4:0] reg_decode(logic [3:0] a);
    if (a < dpa_pkg::REG_CH_STRIDE)
      return {1'b0, a};
    if (a < dpa_pkg::REG_ACCESS_CTRL)
      return {1'b1, a - dpa_pkg::REG_CH_STRIDE};
    return 5'h1f;
  endfunction

  function automatic logic [11:0] clamp_time(logic [31:0] w);
    return (w > 32'(dpa_pkg::TIMER_MAX_S)) ? dpa_pkg::TIMER_MAX_S
                                            : w[11:0];
  endfunction
  wire logic [4:0] reg_idx = reg_decode(reg_addr_i);
  // One second tick and a flash phase that toggles on it
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      blink <= 1'b0;
      label_seq <= 2'h0;
    end
    else if (tick)
    begin
      blink <= !blink;
      label_seq <= label_seq + 2'h1;
    end
  end

  dpa_sync #(
    .W(4)
  ) u_btn_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i({btn_enter_i, btn_down_i, btn_up_i, btn_p_i}),
    .sync_o(btn_sync)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      btn_prev <= '0;
    else
      btn_prev <= btn_sync;
  end

  assign p_rise = btn_sync[0] && !btn_prev[0];
  assign up_rise = btn_sync[1] && !btn_prev[1];
  assign down_rise = btn_sync[2] && !btn_prev[2];
  assign enter_rise = btn_sync[3] && !btn_prev[3];
  assign combo_rise = btn_sync[0] && btn_sync[1] &&
                      !(btn_prev[0] && btn_prev[1]);

  // P alone in display mode accepts or clears; the combo enters setpoints
  assign accept = (ed_state == ED_DISPLAY) && p_rise && !btn_sync[1];
  assign clear_latch = accept;

  // Register file; a bus write wins over a setpoint stored from the panel
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        cfg[c] <= dpa_pkg::CFG_RST;
        sp[c] <= dpa_pkg::NUM_RST;
        hyst[c] <= dpa_pkg::NUM_RST;
        delay_s[c] <= '0;
        silence_s[c] <= '0;
      end
    end
    else
    begin
      if (store_sp)
        sp[ed_sel] <= ed_buf;
      if (reg_we_i && reg_idx != 5'h1f)
      begin
        unique case (reg_idx[3:0])
          dpa_pkg::REG_CTRL:
            cfg[reg_idx[4]] <= reg_wdata_i[8:0];
          dpa_pkg::REG_SETPOINT:
            sp[reg_idx[4]] <= reg_wdata_i[23:0];
          dpa_pkg::REG_HYST:
            hyst[reg_idx[4]] <= {1'b0, reg_wdata_i[22:0]};
          dpa_pkg::REG_DELAY:
            delay_s[reg_idx[4]] <= clamp_time(reg_wdata_i);
          dpa_pkg::REG_SILENCE:
            silence_s[reg_idx[4]] <= clamp_time(reg_wdata_i);
          default:
            ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      access_en <= 1'b0;
      access_code <= dpa_pkg::ACCESS_CODE_RST;
    end
    else if (reg_we_i && reg_addr_i == dpa_pkg::REG_ACCESS_CTRL)
      access_en <= reg_wdata_i[0];
    else if (reg_we_i && reg_addr_i == dpa_pkg::REG_ACCESS_CODE)
      access_code <= reg_wdata_i[15:0];
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= '0;
    else if (reg_re_i)
    begin
      reg_rdata_o <= '0;
      if (reg_addr_i == dpa_pkg::REG_ACCESS_CTRL)
        reg_rdata_o <= {31'h0, access_en};
      else if (reg_addr_i == dpa_pkg::REG_ACCESS_CODE)
        reg_rdata_o <= {16'h0, access_code};
      else if (reg_addr_i == dpa_pkg::REG_STATUS)
        reg_rdata_o <= {24'h0, relay_o, cond, pending, active};
      else if (reg_idx != 5'h1f)
      begin
        unique case (reg_idx[3:0])
          dpa_pkg::REG_CTRL:
            reg_rdata_o <= {23'h0, cfg[reg_idx[4]]};
          dpa_pkg::REG_SETPOINT:
            reg_rdata_o <= {8'h0, sp[reg_idx[4]]};
          dpa_pkg::REG_HYST:
            reg_rdata_o <= {8'h0, hyst[reg_idx[4]]};
          dpa_pkg::REG_DELAY:
            reg_rdata_o <= {20'h0, delay_s[reg_idx[4]]};
          dpa_pkg::REG_SILENCE:
            reg_rdata_o <= {20'h0, silence_s[reg_idx[4]]};
          default:
            reg_rdata_o <= '0;
        endcase
      end
    end
  end

  assign disp_scaled = dpa_pkg::dpa_scale(display_i);

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    dpa_channel u_ch (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .tick_i(tick),
      .cfg_i(cfg[g]),
      .delay_i(delay_s[g]),
      .silence_i(silence_s[g]),
      .disp_i(disp_scaled),
      .sp_i(dpa_pkg::dpa_scale(sp[g])),
      .hyst_i(dpa_pkg::dpa_scale(hyst[g])),
      .accept_i(accept),
      .clear_i(clear_latch),
      .loop_break_i(loop_break_i),
      .cond_o(cond[g]),
      .active_o(active[g]),
      .pending_o(pending[g]),
      .relay_o(relay_o[g])
    );
  end

  // Direct setpoint access from display mode
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ed_state <= ED_DISPLAY;
      ed_sel <= 1'b0;
      ed_pos <= '0;
      ed_buf <= dpa_pkg::NUM_RST;
      code_buf <= '0;
      store_sp <= 1'b0;
    end
    else
    begin
      store_sp <= 1'b0;
      unique case (ed_state)
        ED_DISPLAY:
          if (combo_rise && access_en)
          begin
            ed_pos <= '0;
            code_buf <= '0;
            ed_sel <= 1'b0;
            ed_state <= (access_code == 16'h0000) ? ED_SELECT
                                                  : ED_CODE;
          end
        ED_CODE:
          if (up_rise || down_rise)
            code_buf[(3 - ed_pos[1:0])*4 +: 4] <= dpa_pkg::dpa_digit_step(
              code_buf[(3 - ed_pos[1:0])*4 +: 4], up_rise);
          else if (p_rise)
            ed_pos <= (ed_pos[1:0] == dpa_pkg::CODE_POS_LAST) ? 3'h0
                      : ed_pos + 3'h1;
          else if (enter_rise)
            ed_state <= (code_buf == access_code) ? ED_SELECT
                                                  : ED_DISPLAY;
        ED_SELECT:
          if (up_rise || down_rise)
            ed_sel <= !ed_sel;
          else if (p_rise)
          begin
            ed_buf <= sp[ed_sel];
            ed_pos <= '0;
            ed_state <= ED_EDIT;
          end
          else if (enter_rise)
            ed_state <= ED_DISPLAY;
        ED_EDIT:
          if (up_rise || down_rise)
          begin
            if (ed_pos == dpa_pkg::POS_DP)
              ed_buf.dp <= up_rise
                ? ((ed_buf.dp >= dpa_pkg::MAX_DP) ? 3'h0 : ed_buf.dp + 3'h1)
                : ((ed_buf.dp == 3'h0) ? dpa_pkg::MAX_DP : ed_buf.dp - 3'h1);
            else if (ed_pos == dpa_pkg::POS_SIGN)
              ed_buf.neg <= !ed_buf.neg;
            else
              ed_buf.digits[(4 - ed_pos)*4 +: 4] <= dpa_pkg::dpa_digit_step(
                ed_buf.digits[(4 - ed_pos)*4 +: 4], up_rise);
          end
          else if (p_rise)
            ed_pos <= (ed_pos == dpa_pkg::POS_SIGN) ? 3'h0
                      : ed_pos + 3'h1;
          else if (enter_rise)
          begin
            store_sp <= 1'b1;
            ed_state <= ED_SELECT;
          end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      edit_o <= '0;
    else
    begin
      edit_o.active <= (ed_state != ED_DISPLAY);
      edit_o.target <= (ed_state == ED_CODE) ? 2'h0 : {1'b1, ed_sel};
      edit_o.pos <= ed_pos;
      edit_o.value <= (ed_state == ED_CODE)
                      ? {4'h0, code_buf, 4'h0} : ed_buf;
    end
  end

  // Annunciators, colour and identification labels
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      annunciator_o <= '0;
      disp_colour_o <= '0;
      disp_alarm_colour_o <= 1'b0;
      show_label_o <= 1'b0;
      label_sel_o <= 1'b0;
    end
    else
    begin
      annunciator_o <= active | (pending & {2{blink}});
      disp_alarm_colour_o <= 1'b1;
      if (active[1])
        disp_colour_o <= cfg[1].colour;
      else if (active[0])
        disp_colour_o <= cfg[0].colour;
      else if (pending[1] && cfg[1].colour_chg && blink)
        disp_colour_o <= cfg[1].colour;
      else if (pending[0] && cfg[0].colour_chg && blink)
        disp_colour_o <= cfg[0].colour;
      else
      begin
        disp_colour_o <= '0;
        disp_alarm_colour_o <= 1'b0;
      end
      // Only activated outputs flash a label, never delay or silence
      show_label_o <= label_seq[0] &&
                      |(active & {cfg[1].flash, cfg[0].flash});
      label_sel_o <= (active[0] && cfg[0].flash &&
                      active[1] && cfg[1].flash)
                     ? label_seq[1] : (active[1] && cfg[1].flash);
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_both_colour_two: assert property (
    &active |=> disp_alarm_colour_o && disp_colour_o == $past(cfg[1].colour))
    else $error("both active did not show alarm two colour");
  a_access_off: assert property (
    ed_state == ED_DISPLAY && !access_en |=> ed_state == ED_DISPLAY)
    else $error("setpoint access entered while disabled");
  a_label_needs_active: assert property (
    show_label_o |-> $past(|active)) else $error("label without activation");
  a_wrong_code_exit: assert property (
    ed_state == ED_CODE && enter_rise && !up_rise && !down_rise && !p_rise
    && code_buf != access_code |=> ed_state == ED_DISPLAY)
    else $error("wrong code did not return to display");

  c_enter_edit: cover property (ed_state == ED_SELECT ##1 ed_state == ED_EDIT);
  c_both_active: cover property (&active);
  c_label_shown: cover property (show_label_o && label_sel_o);
endmodule

// File: design/dpa_pkg.sv
// Shared constants, types and helpers of the dual process alarm
package dpa_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_PERIOD_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned TIMER_W = 12;
  localparam logic [11:0] TIMER_MAX_S = 12'he10;
  localparam int unsigned NUM_DIGITS = 5;
  localparam int unsigned CODE_DIGITS = 4;
  localparam logic [2:0] MAX_DP = 3'h4;
  localparam logic [2:0] POS_DP = 3'h5;
  localparam logic [2:0] POS_SIGN = 3'h6;
  localparam logic [1:0] CODE_POS_LAST = 2'h3;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SETPOINT = 4'h1;
  localparam logic [3:0] REG_HYST = 4'h2;
  localparam logic [3:0] REG_DELAY = 4'h3;
  localparam logic [3:0] REG_SILENCE = 4'h4;
  localparam logic [3:0] REG_CH_STRIDE = 4'h5;
  localparam logic [3:0] REG_ACCESS_CTRL = 4'ha;
  localparam logic [3:0] REG_ACCESS_CODE = 4'hb;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam logic [15:0] ACCESS_CODE_RST = 16'h0000;

  typedef struct packed {
    logic [2:0] colour;
    logic colour_chg;
    logic latch;
    logic flash;
    logic rest_energised;
    logic high;
    logic enable;
  } dpa_cfg_s;

  typedef struct packed {
    logic neg;
    logic [2:0] dp;
    logic [19:0] digits;
  } dpa_num_s;

  typedef struct packed {
    logic active;
    logic [1:0] target;
    logic [2:0] pos;
    dpa_num_s value;
  } dpa_edit_s;

  typedef enum logic [1:0] {CH_IDLE, CH_DELAY, CH_ACTIVE, CH_SILENCE} dpa_ch_e;

  localparam dpa_cfg_s CFG_RST = '0;
  localparam dpa_num_s NUM_RST = '0;

  // Value in units of 10^-4, so numbers with different points compare
  function automatic logic signed [39:0] dpa_scale(dpa_num_s n);
    logic signed [39:0] v;
    v = '0;
    for (int i = NUM_DIGITS - 1; i >= 0; i--)
      v = v * 40'sd10 + $signed({36'h0, n.digits[i*4 +: 4]});
    for (int j = 0; j < 4; j++)
      if (j >= int'(n.dp))
        v = v * 40'sd10;
    return n.neg ? -v : v;
  endfunction

  function automatic logic [3:0] dpa_digit_step(logic [3:0] d, logic up);
    if (up)
      return (d >= 4'h9) ? 4'h0 : d + 4'h1;
    return (d == 4'h0) ? 4'h9 : d - 4'h1;
  endfunction
endpackage

// File: design/dpa_sync.sv
// Two-flop synchroniser for asynchronous push-button levels
`timescale 1ns/1ps
module dpa_sync #(
  parameter int unsigned W = 4
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// File: test/dpa_dual_alarm_tb.sv
// Self-checking bench of the dual process alarm
`timescale 1ns/1ps
module dpa_dual_alarm_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic [3:0] btn;
  logic show_lbl;
  logic lbl_sel;
  dpa_pkg::dpa_edit_s edit;
  logic [1:0] seen;
  dpa_pkg::dpa_num_s disp = 24'h000000;
  logic loop_brk = 1'b0;
  logic [1:0] relay;
  logic [1:0] annun;
  logic [2:0] colour;
  logic alarm_col;
  logic [31:0] q;
  logic [31:0] v;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  dpa_dual_alarm #(.TICK_CYCLES(8)) dpa_dual_alarm_i (
    .clk_sys_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .btn_p_i(btn[0]), .btn_up_i(btn[1]),
    .btn_down_i(btn[2]), .btn_enter_i(btn[3]), .display_i(disp),
    .loop_break_i(loop_brk), .relay_o(relay), .annunciator_o(annun),
    .disp_colour_o(colour), .disp_alarm_colour_o(alarm_col),
    .show_label_o(show_lbl), .label_sel_o(lbl_sel), .edit_o(edit)
  );

  dpa_panel_model dpa_panel_model_i (.clk_sys_i(clk), .btn_o(btn));

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      $display("ERROR %0t run did not finish", $time);
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Returns just after the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    q = rdata;
  endtask

  function automatic logic [31:0] clamp(input logic [31:0] x);
    return (x > 32'he10) ? 32'he10 : x;
  endfunction

  initial
  begin
    void'($urandom(19586));
    cyc(8);
    arst_n <= 1'b1;
    cyc(2);
    chk(relay, 2'b00);
    rd(4'hc);
    chk(q, 32'h0);
    wr(4'h1, 32'h000100);
    wr(4'h2, 32'h000005);
    wr(4'h0, 32'h0c3);
    wr(4'h6, 32'h000050);
    // Energised rest state chosen for fail-safe wiring
    wr(4'h5, 32'h147);
    cyc(2);
    chk(relay, 2'b10);
    disp <= 24'h000099;
    cyc(4);
    chk(relay, 2'b00);
    disp <= 24'h000100;
    cyc(4);
    chk(relay, 2'b01);
    chk(colour, 3'h5);
    disp <= 24'h000096;
    cyc(4);
    chk(relay, 2'b01);
    disp <= 24'h000094;
    cyc(4);
    chk(relay, 2'b00);
    chk({alarm_col, colour}, 4'hd);
    wr(4'h3, 32'h2);
    disp <= 24'h000100;
    cyc(14);
    chk(relay[0], 1'b0);
    disp <= 24'h000000;
    cyc(3);
    disp <= 24'h000100;
    cyc(14);
    chk(relay[0], 1'b0);
    cyc(16);
    chk(relay[0], 1'b1);
    chk(annun[0], 1'b1);
    wr(4'h3, 32'h0);
    wr(4'h0, 32'h0d3);
    disp <= 24'h000000;
    cyc(4);
    chk(relay, 2'b11);
    dpa_panel_model_i.press(4'h1);
    cyc(6);
    chk(relay, 2'b10);
    loop_brk <= 1'b1;
    cyc(2);
    chk(relay, 2'b00);
    loop_brk <= 1'b0;
    repeat (6)
    begin
      v = $urandom % 8192;
      wr(4'h4, v);
      rd(4'h4);
      chk(q, clamp(v));
    end
    wr(4'hd, 32'h5a);
    rd(4'hd);
    chk(q, 32'h0);
    wr(4'h4, 32'h1);
    disp <= 24'h000100;
    cyc(4);
    chk(relay[0], 1'b1);
    dpa_panel_model_i.press(4'h1);
    cyc(3);
    chk(relay[0], 1'b0);
    cyc(25);
    chk(relay[0], 1'b1);
    // Both alarms active with label flashing: both labels take turns
    wr(4'h0, 32'h0db);
    wr(4'h5, 32'h14f);
    seen = 2'b00;
    repeat (40)
    begin
      cyc(1);
      if (show_lbl)
        seen[lbl_sel] = 1'b1;
    end
    chk(seen, 2'b11);
    // Access switched off: the P and up combination is ignored
    dpa_panel_model_i.press(4'h3);
    cyc(1);
    chk(edit.active, 1'b0);
    wr(4'ha, 32'h1);
    wr(4'hb, 32'h0001);
    dpa_panel_model_i.press(4'h3);
    cyc(1);
    chk({edit.active, edit.target}, 3'b100);
    dpa_panel_model_i.press(4'h8);
    cyc(1);
    chk(edit.active, 1'b0);
    dpa_panel_model_i.press(4'h3);
    repeat (3) dpa_panel_model_i.press(4'h1);
    dpa_panel_model_i.press(4'h2);
    cyc(1);
    chk({edit.pos, edit.value}, {3'h3, 24'h000010});
    dpa_panel_model_i.press(4'h8);
    cyc(1);
    chk({edit.active, edit.target}, 3'b110);
    // Edit alarm one: first digit down to 9, then point one place
    dpa_panel_model_i.press(4'h1);
    dpa_panel_model_i.press(4'h4);
    repeat (5) dpa_panel_model_i.press(4'h1);
    dpa_panel_model_i.press(4'h2);
    cyc(1);
    chk({edit.pos, edit.value}, {3'h5, 24'h190100});
    dpa_panel_model_i.press(4'h8);
    rd(4'h1);
    chk(q, 32'h190100);
    results();
  end
endmodule

// File: test/dpa_panel_model.sv
// Operator front panel model: presses P, up, down and enter buttons
`timescale 1ns/1ps
module dpa_panel_model (
  input wire logic clk_sys_i,
  output logic [3:0] btn_o
);
  initial btn_o = 4'h0;

  // Held past the two-flop sync so the edge is always seen; bits are
  // {enter, down, up, P}, several at once for the access combination
  task automatic press(input logic [3:0] b);
    @(posedge clk_sys_i);
    btn_o <= b;
    repeat (4) @(posedge clk_sys_i);
    btn_o <= 4'h0;
  endtask
endmodule
